// >>> hw/low_power_watchdog_control.sv
// Low-power mode sequencer with fixed and programmable watchdogs and clock monitor
`timescale 1ns/1ps
`default_nettype none
`include "lowpwr_defines.svh"

module low_power_watchdog_control #(
  parameter int FIXED_WDOG_CYCLES = `FIXED_WDOG_CYCLES,
  parameter int PROG_WDOG_CYCLES = `PROG_WDOG_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic halt_exec_i,
  input wire logic idle_exec_i,
  input wire logic int_req_i,
  input wire logic irq_n_pin_i,
  input wire logic reset_n_pin_i,
  output logic reset_n_pin_o,
  output logic reset_n_pin_oe_o,
  input wire logic clock_absent_i,
  input wire logic bootloader_mode_i,
  input wire logic fixed_watchdog_enable_option_i,
  input wire logic [7:0] mask_option_reg_one_i,
  output logic sys_reset_o,
  output logic osc_enable_o,
  output logic cpu_clock_enable_o,
  output logic periph_clock_enable_o,
  output logic interrupt_mask_clear_o,
  output logic sci_freeze_o,
  output logic spi_master_freeze_o,
  output logic spi_clear_o,
  output logic spi_slave_flags_hold_o
);

  // ----------------------------------------
  // Widths and limits
  // ----------------------------------------
  localparam int FW = $clog2(FIXED_WDOG_CYCLES);
  localparam int PW = $clog2(PROG_WDOG_CYCLES);
  localparam int MW = $clog2(`CLKMON_CYCLES);
  localparam logic [FW-1:0] FIX_LAST = FW'(FIXED_WDOG_CYCLES - 1);
  localparam logic [PW-1:0] PROG_LAST = PW'(PROG_WDOG_CYCLES - 1);
  localparam logic [MW-1:0] MON_LAST = MW'(`CLKMON_CYCLES - 1);
  localparam logic [11:0] STAB_LAST = 12'(`STAB_CYCLES - 1);
  localparam logic [2:0] PULSE_LEN = 3'(`RESET_PULSE_CYCLES);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    lowpwr_pkg::pwr_state_t state;
    logic [1:0] rst_sync;
    logic [1:0] irq_sync;
    logic [1:0] abs_sync;
    logic ack;
    logic [7:0] rdata;
    logic clkchk_en;
    logic progwd_en;
    logic progwd_lock;
    logic key1_seen;
    logic fault;
    logic [FW-1:0] fix_cnt;
    logic [PW-1:0] prog_cnt;
    logic [11:0] stab_cnt;
    logic [MW-1:0] mon_cnt;
    logic [2:0] pulse_cnt;
    logic abs_hold;
    logic drive;
    logic [1:0] guard;
    logic wake_by_reset;
    logic sys_reset;
    logic osc_en;
    logic cpu_en;
    logic mask_clr;
    logic spi_clr;
  } lpw_state_t;

  lpw_state_t s;
  lpw_state_t next_s;

  logic req;
  logic acc_wr;
  logic acc_rd;
  logic fix_enable;
  logic ext_reset;
  logic irq_wake;
  logic clk_missing;
  logic mon_fire;
  logic fix_timeout;
  logic prog_timeout;
  logic fix_service;
  logic int_reset;

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  always_comb begin
    req = wb_cyc_i & wb_stb_i;
    acc_wr = req & s.ack & wb_we_i;
    acc_rd = req & s.ack & ~wb_we_i;
    fix_enable = fixed_watchdog_enable_option_i & ~bootloader_mode_i;
    // Own drive reads back low; the guard covers the pin's rise through the synchroniser
    ext_reset = ~s.rst_sync[1] & ~s.drive & (s.guard == 2'h0);
    irq_wake = ~s.irq_sync[1];
    // stopped oscillator counts as absent clock
    clk_missing = (s.state == lowpwr_pkg::st_halt) | s.abs_sync[1];
    mon_fire = s.clkchk_en & clk_missing & (s.mon_cnt == MON_LAST);
    fix_timeout = fix_enable & (s.fix_cnt == FIX_LAST);
    prog_timeout = s.progwd_en & (s.prog_cnt == PROG_LAST);
    // write of zero to bit 0 restarts fixed watchdog
    fix_service = acc_wr & (wb_adr_i == `FIXCLR_ADDR) & wb_sel_i[0] & ~wb_dat_i[0];
    int_reset = mon_fire | fix_timeout | prog_timeout;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.rst_sync = {s.rst_sync[0], reset_n_pin_i};
    next_s.irq_sync = {s.irq_sync[0], irq_n_pin_i};
    next_s.abs_sync = {s.abs_sync[0], clock_absent_i};
    next_s.mask_clr = 1'b0;
    next_s.spi_clr = 1'b0;

    // Bus slave: one wait state, unmapped reads give zero
    next_s.ack = req & ~s.ack;
    if (req & ~s.ack & ~wb_we_i) begin
      case (wb_adr_i)
        `CTRL_ADDR: next_s.rdata = {5'h00, s.fault, s.progwd_en, s.clkchk_en};
        `STAT_ADDR: next_s.rdata = {4'h0, s.state};
        `FIXCLR_ADDR: next_s.rdata = mask_option_reg_one_i;
        default: next_s.rdata = 8'h00;
      endcase
    end

    if (acc_wr & wb_sel_i[0] & (wb_adr_i == `CTRL_ADDR)) begin
      next_s.clkchk_en = wb_dat_i[`CTRL_CLKCHK_BIT];
      // Enable of the programmable watchdog is write-once until reset
      if (!s.progwd_lock) begin
        next_s.progwd_en = wb_dat_i[`CTRL_PROGWD_BIT];
        next_s.progwd_lock = 1'b1;
      end
    end
    if (acc_rd & (wb_adr_i == `CTRL_ADDR)) begin
      next_s.fault = 1'b0;
    end

    // Programmable watchdog service pair
    if (acc_wr & wb_sel_i[0] & (wb_adr_i == `PSVC_ADDR)) begin
      if (wb_dat_i[7:0] == `PSVC_KEY1) begin
        next_s.key1_seen = 1'b1;
      end else if ((wb_dat_i[7:0] == `PSVC_KEY2) && s.key1_seen) begin
        next_s.key1_seen = 1'b0;
        next_s.prog_cnt = '0;
      end
    end

    // ----------------------------------------
    // Fixed watchdog
    // ----------------------------------------
    if (!fix_enable) begin
      next_s.fix_cnt = '0;
    end else if (fix_service || fix_timeout) begin
      next_s.fix_cnt = '0;
    end else if (s.state != lowpwr_pkg::st_halt) begin
      // counts in idle and run alike
      next_s.fix_cnt = s.fix_cnt + 1'b1;
    end

    // ----------------------------------------
    // Programmable watchdog
    // ----------------------------------------
    if (prog_timeout) begin
      next_s.prog_cnt = '0;
    end else if (s.progwd_en && (s.state == lowpwr_pkg::st_run ||
                                 s.state == lowpwr_pkg::st_idle)) begin
      next_s.prog_cnt = s.prog_cnt + 1'b1;
    end

    // ----------------------------------------
    // Clock monitor
    // ----------------------------------------
    if (s.clkchk_en && clk_missing && !mon_fire) begin
      next_s.mon_cnt = s.mon_cnt + 1'b1;
    end else begin
      next_s.mon_cnt = '0;
    end
    if (s.pulse_cnt != 3'h0) begin
      next_s.pulse_cnt = s.pulse_cnt - 3'h1;
    end
    if (!s.abs_sync[1]) begin
      next_s.abs_hold = 1'b0;
    end
    if (mon_fire) begin
      // monitor sets fault flag; set wins over read clear
      next_s.fault = 1'b1;
      next_s.pulse_cnt = PULSE_LEN;
      // absent clock keeps pin low until recovery
      next_s.abs_hold = s.abs_sync[1];
    end
    if (prog_timeout) begin
      next_s.fault = 1'b1;
    end
    next_s.drive = (next_s.pulse_cnt != 3'h0) | next_s.abs_hold;
    if (s.drive) begin
      next_s.guard = 2'h3;
    end else if (s.guard != 2'h0) begin
      next_s.guard = s.guard - 2'h1;
    end

    // ----------------------------------------
    // Power mode sequencing
    // ----------------------------------------
    case (s.state)
      lowpwr_pkg::st_run: begin
        if (halt_exec_i) begin
          next_s.state = lowpwr_pkg::st_halt;
          next_s.mask_clr = 1'b1;
          // fixed counter zeroed on halt entry
          next_s.fix_cnt = '0;
        end else if (idle_exec_i) begin
          // idle clears the mask, gates CPU clock only
          next_s.state = lowpwr_pkg::st_idle;
          next_s.mask_clr = 1'b1;
        end
      end
      lowpwr_pkg::st_idle: begin
        if (int_req_i || irq_wake) begin
          next_s.state = lowpwr_pkg::st_run;
        end
      end
      lowpwr_pkg::st_halt: begin
        // only the interrupt pin or a reset wakes
        if (irq_wake) begin
          next_s.state = lowpwr_pkg::st_stab;
          next_s.wake_by_reset = 1'b0;
          next_s.stab_cnt = 12'h000;
        end
        // programmable counter holds its value in halt
      end
      lowpwr_pkg::st_stab: begin
        if (s.stab_cnt == STAB_LAST) begin
          next_s.state = lowpwr_pkg::st_run;
          // reset wake clears fixed counter once more
          if (s.wake_by_reset) begin
            next_s.fix_cnt = '0;
          end
          // interrupt wake keeps the fixed count
        end else if (!ext_reset) begin
          next_s.stab_cnt = s.stab_cnt + 12'h001;
        end
      end
      default: begin
        next_s.state = lowpwr_pkg::st_run;
      end
    endcase

    // Any internal or pin reset restarts the clock sequence; the fault flag survives it (rst_i clears it)
    next_s.sys_reset = int_reset | ext_reset;
    if (int_reset || ext_reset) begin
      next_s.state = lowpwr_pkg::st_stab;
      next_s.stab_cnt = 12'h000;
      next_s.wake_by_reset = 1'b1;
      next_s.clkchk_en = 1'b0;
      // reset wake clears and disables programmable watchdog
      next_s.progwd_en = 1'b0;
      next_s.progwd_lock = 1'b0;
      next_s.key1_seen = 1'b0;
      next_s.prog_cnt = '0;
      next_s.spi_clr = 1'b1;
      // fixed watchdog counts at once from zero unless the reset comes in st_stab, where it keeps its count
      if (s.state != lowpwr_pkg::st_stab) begin
        next_s.fix_cnt = '0;
      end
    end

    next_s.osc_en = (next_s.state != lowpwr_pkg::st_halt);
    next_s.cpu_en = (next_s.state == lowpwr_pkg::st_run);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.state <= lowpwr_pkg::st_run;
      s.rst_sync <= 2'h3;
      s.irq_sync <= 2'h3;
      s.rdata <= `CTRL_RESET;
      s.osc_en <= 1'b1;
      s.cpu_en <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_dat_o = {24'h000000, s.rdata};
  assign wb_ack_o = s.ack;
  assign reset_n_pin_o = 1'b0;
  assign reset_n_pin_oe_o = s.drive;
  assign sys_reset_o = s.sys_reset;
  assign osc_enable_o = s.osc_en;
  assign cpu_clock_enable_o = s.cpu_en;
  // peripherals keep their clock in idle
  assign periph_clock_enable_o = s.osc_en;
  assign interrupt_mask_clear_o = s.mask_clr;
  // serial transmit frozen while oscillator stops
  assign sci_freeze_o = ~s.osc_en;
  assign spi_master_freeze_o = ~s.osc_en;
  assign spi_clear_o = s.spi_clr;
  assign spi_slave_flags_hold_o = ~s.osc_en;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  localparam int MON_MAX = `CLKMON_CYCLES + 8;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  fix_clear_a: assert property (fix_service && fix_enable |=> s.fix_cnt <= 1)
    else $error("fixed watchdog not restarted by clear write");

  read_option_a: assert property (
    req && !s.ack && !wb_we_i && wb_adr_i == `FIXCLR_ADDR
    |=> wb_ack_o && wb_dat_o[7:0] == $past(mask_option_reg_one_i))
    else $error("clear location read did not return option register");

  boot_off_a: assert property (bootloader_mode_i |=> s.fix_cnt == 0)
    else $error("fixed watchdog counts in bootloader mode");

  mon_fire_a: assert property (
    s.state == lowpwr_pkg::st_halt && s.clkchk_en |-> ##[1:MON_MAX] sys_reset_o && s.fault)
    else $error("clock monitor missed stopped clock");

  pulse_len_a: assert property ($rose(reset_n_pin_oe_o) |-> reset_n_pin_oe_o[*4])
    else $error("reset pin pulse shorter than four cycles");

  halt_osc_a: assert property (
    (s.state == lowpwr_pkg::st_halt) == !osc_enable_o)
    else $error("oscillator enable disagrees with halt");

  halt_mask_a: assert property (
    $rose(s.state == lowpwr_pkg::st_halt) |-> interrupt_mask_clear_o)
    else $error("interrupt mask not cleared on halt");

  halt_exit_a: assert property (
    s.state == lowpwr_pkg::st_halt ##1 s.state != lowpwr_pkg::st_halt
    |-> $past(irq_wake || ext_reset || int_reset))
    else $error("halt left without a wake source");

  prog_hold_a: assert property (
    s.state == lowpwr_pkg::st_halt ##1 s.state == lowpwr_pkg::st_halt
    |-> s.prog_cnt == $past(s.prog_cnt))
    else $error("programmable watchdog moved in halt");

  fix_halt_a: assert property (s.state == lowpwr_pkg::st_halt |-> s.fix_cnt == 0)
    else $error("fixed watchdog nonzero in halt");

  stab_clear_a: assert property (
    s.state == lowpwr_pkg::st_stab && s.stab_cnt == STAB_LAST && s.wake_by_reset
    && !int_reset && !ext_reset |=> s.fix_cnt == 0)
    else $error("fixed watchdog not cleared after reset wake delay");

  idle_clk_a: assert property (
    s.state == lowpwr_pkg::st_idle |-> !cpu_clock_enable_o && periph_clock_enable_o)
    else $error("idle clock gating wrong");

  irq_wake_c: cover property (s.state == lowpwr_pkg::st_halt ##1 s.state == lowpwr_pkg::st_stab
    && !s.wake_by_reset);
  rst_wake_c: cover property (s.state == lowpwr_pkg::st_halt ##1 s.wake_by_reset);
  idle_exit_c: cover property (s.state == lowpwr_pkg::st_idle ##1 s.state == lowpwr_pkg::st_run);
  mon_fire_c: cover property (mon_fire);

endmodule
`default_nettype wire

// >>> hw/lowpwr_defines.svh
// Constants for the low-power and watchdog control block
// Operation
// - Writing 0 to bit 0 of the clear location restarts the fixed watchdog.
// - Reading the clear location returns mask option register one.
// - Fixed watchdog stays off in bootloader mode despite its enable option.
// - With clock check enabled, absent bus clock is detected after a timeout.
// - A detected clock failure resets the system, reset pin low four cycles.
// - Halt with clock check enabled makes the monitor time out and reset.
// - Halt stops the oscillator, timer, serial port and master SPI.
// - Halt entry clears the interrupt mask and zeroes the fixed watchdog count; other state is kept.
// - Only an interrupt pin or a reset ends halt.
// - Serial transmit freezes in halt and resumes on an interrupt wake.
// - Master SPI pauses in halt; a reset wake clears and disables SPI.
// - Slave SPI runs in halt but its flags stay held until interrupt wake.
// - Halt suspends the programmable watchdog; reset wake clears and disables it.
// - Interrupt wake resumes the programmable watchdog after the stabilization delay.
// - Halt entry stops and zeroes the fixed watchdog counter.
// - Reset wake: fixed watchdog counts at once, cleared again after stabilization.
// - Interrupt wake: fixed watchdog counts at once, not cleared after delay.
// - Idle stops only the CPU; any interrupt or reset ends idle.
// - Idle clears the interrupt mask and gates the CPU clock only.
// - Both watchdogs keep counting in idle; software must service them.
// - A clock monitor event also sets the watchdog fault flag.
// - An absent clock holds the reset pin low until the clock recovers.
`ifndef LOWPWR_DEFINES_SVH
`define LOWPWR_DEFINES_SVH
`define CTRL_ADDR 16'h0000
`define PSVC_ADDR 16'h0004
`define STAT_ADDR 16'h0008
`define FIXCLR_ADDR 16'h1FF0
`define CTRL_CLKCHK_BIT 0
`define CTRL_PROGWD_BIT 1
`define CTRL_FAULT_BIT 2
`define CTRL_RESET 8'h00
`define PSVC_KEY1 8'h55
`define PSVC_KEY2 8'hAA
`define CLK_PERIOD_NS 10
`define CLKMON_TIMEOUT_NS 5000
`define CLKMON_CYCLES ((`CLKMON_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_CYCLES 4
`define STAB_CYCLES 4064
`define FIXED_WDOG_CYCLES 131072
`define PROG_WDOG_CYCLES 32768
`endif

// >>> hw/lowpwr_pkg.sv
// Types shared by the low-power and watchdog control block
package lowpwr_pkg;
  typedef enum logic [3:0] {
    st_run = 4'h1,
    st_idle = 4'h2,
    st_halt = 4'h4,
    st_stab = 4'h8
  } pwr_state_t;
endpackage

// >>> test/low_power_watchdog_control_test.sv
// Self-checking bench for the low-power and watchdog control block
`timescale 1ns/1ps
`default_nettype none
`include "lowpwr_defines.svh"

module low_power_watchdog_control_test;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, d;
  logic wb_ack_o, halt_exec_i = 1'b0, idle_exec_i = 1'b0, int_req_i = 1'b0, irq_req = 1'b0;
  logic rst_req = 1'b0, irq_n_pin_i, reset_n_pin_i, reset_n_pin_oe_o, clock_absent_i = 1'b0;
  logic bootloader_mode_i = 1'b0, fixed_watchdog_enable_option_i = 1'b0, sys_reset_o;
  logic [7:0] mask_option_reg_one_i = 8'hA5;
  logic osc_enable_o, cpu_clock_enable_o, periph_clock_enable_o, interrupt_mask_clear_o;
  logic sci_freeze_o, spi_master_freeze_o, spi_clear_o, spi_slave_flags_hold_o;
  int fails = 0, n_compared = 0, n_sys = 0, n_oe = 0, n_spi = 0, n_mask = 0, s;
  typedef struct {logic we; logic [15:0] a; logic [31:0] wd; logic [31:0] exp;} row_t;
  row_t rows[8] = '{
    '{1'b0, `STAT_ADDR, 32'h0, 32'h1}, '{1'b0, `PSVC_ADDR, 32'h0, 32'h0},
    '{1'b0, 16'h0100, 32'h0, 32'h0}, '{1'b0, `FIXCLR_ADDR, 32'h0, 32'h0000_00A5},
    '{1'b1, `CTRL_ADDR, 32'h1, 32'h1}, '{1'b1, `CTRL_ADDR, 32'h0, 32'h0},
    '{1'b1, `STAT_ADDR, 32'hF, 32'h1}, '{1'b1, 16'h0100, 32'hF, 32'h0}};

  low_power_watchdog_control #(.FIXED_WDOG_CYCLES(64), .PROG_WDOG_CYCLES(64)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .halt_exec_i(halt_exec_i),
    .idle_exec_i(idle_exec_i), .int_req_i(int_req_i), .irq_n_pin_i(irq_n_pin_i),
    .reset_n_pin_i(reset_n_pin_i), .reset_n_pin_o(), .reset_n_pin_oe_o(reset_n_pin_oe_o),
    .clock_absent_i(clock_absent_i), .bootloader_mode_i(bootloader_mode_i),
    .fixed_watchdog_enable_option_i(fixed_watchdog_enable_option_i),
    .mask_option_reg_one_i(mask_option_reg_one_i), .sys_reset_o(sys_reset_o),
    .osc_enable_o(osc_enable_o), .cpu_clock_enable_o(cpu_clock_enable_o),
    .periph_clock_enable_o(periph_clock_enable_o),
    .interrupt_mask_clear_o(interrupt_mask_clear_o), .sci_freeze_o(sci_freeze_o),
    .spi_master_freeze_o(spi_master_freeze_o), .spi_clear_o(spi_clear_o),
    .spi_slave_flags_hold_o(spi_slave_flags_hold_o));

  lowpwr_ext_party #(.SLOW(1)) party_u (.clk_i(clk_i), .irq_req_i(irq_req),
    .rst_req_i(rst_req), .reset_n_pin_oe_i(reset_n_pin_oe_o),
    .irq_n_pin_o(irq_n_pin_i), .reset_n_pin_o(reset_n_pin_i));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // Event counters sampled mid-cycle so they never race the design's edge
  always @(negedge clk_i) begin
    n_sys += (sys_reset_o === 1'b1);
    n_oe += (reset_n_pin_oe_o === 1'b1);
    n_spi += (spi_clear_o === 1'b1);
    n_mask += (interrupt_mask_clear_o === 1'b1);
  end

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [15:0] a, input logic [31:0] wd,
                         output logic [31:0] rd);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hF;
    i = 0;
    // Ack and read data are taken at the rising edge where ack is sampled high
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (i >= 50) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Polls the status register until the sequencer is back in run
  task automatic wait_run(output logic [31:0] st);
    int i;
    st = 32'h0;
    for (i = 0; i < 300 && st !== 32'h1; i++) begin
      wait_cyc(20);
      wb_xfer(1'b0, `STAT_ADDR, 32'h0, st);
    end
  endtask

  task automatic enter_mode(input logic h);
    @(posedge clk_i);
    halt_exec_i <= h;
    idle_exec_i <= !h;
    @(posedge clk_i);
    halt_exec_i <= 1'b0;
    idle_exec_i <= 1'b0;
    wait_cyc(3);
  endtask

  function automatic logic [31:0] pins();
    return {26'h0, osc_enable_o, cpu_clock_enable_o, periph_clock_enable_o,
            sci_freeze_o, spi_master_freeze_o, spi_slave_flags_hold_o};
  endfunction

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog on the whole run
  // ----------------------------------------
  initial begin
    wait_cyc(60000);
    fails++;
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    wait_cyc(5);
    rst_i <= 1'b0;
    compare(pins(), 32'h38);
    foreach (rows[i]) begin
      if (rows[i].we) wb_xfer(1'b1, rows[i].a, rows[i].wd, d);
      wb_xfer(1'b0, rows[i].a, 32'h0, d);
      compare(d, rows[i].exp);
    end
    fixed_watchdog_enable_option_i <= 1'b1;
    s = n_sys;
    repeat (6) begin
      wait_cyc(30);
      wb_xfer(1'b1, `FIXCLR_ADDR, 32'hFE, d);
    end
    compare(n_sys - s, 0);
    wait_cyc(80);
    compare(n_sys - s, 1);
    fixed_watchdog_enable_option_i <= 1'b0;
    wait_run(d);
    bootloader_mode_i <= 1'b1;
    fixed_watchdog_enable_option_i <= 1'b1;
    s = n_sys;
    wait_cyc(300);
    compare(n_sys - s, 0);
    bootloader_mode_i <= 1'b0;
    s = n_mask;
    enter_mode(1'b0);
    compare(pins(), 32'h28);
    compare(n_mask - s, 1);
    s = n_sys;
    wait_cyc(80);
    compare(n_sys - s, 1);
    fixed_watchdog_enable_option_i <= 1'b0;
    wait_run(d);
    enter_mode(1'b0);
    int_req_i <= 1'b1;
    wait_cyc(3);
    int_req_i <= 1'b0;
    compare(pins(), 32'h38);
    wb_xfer(1'b1, `FIXCLR_ADDR, 32'h0, d);
    fixed_watchdog_enable_option_i <= 1'b1;
    s = n_mask;
    enter_mode(1'b1);
    compare(pins(), 32'h07);
    compare(n_mask - s, 1);
    s = n_sys;
    int_req_i <= 1'b1;
    wait_cyc(300);
    int_req_i <= 1'b0;
    compare(n_sys - s, 0);
    wb_xfer(1'b0, `STAT_ADDR, 32'h0, d);
    compare(d, 32'h4);
    irq_req <= 1'b1;
    wait_cyc(2);
    irq_req <= 1'b0;
    wait_cyc(80);
    compare(n_sys - s, 1);
    fixed_watchdog_enable_option_i <= 1'b0;
    wait_run(d);
    enter_mode(1'b1);
    compare(pins(), 32'h07);
    irq_req <= 1'b1;
    wait_cyc(2);
    irq_req <= 1'b0;
    wait_cyc(4000);
    wb_xfer(1'b0, `STAT_ADDR, 32'h0, d);
    compare(d, 32'h8);
    wait_cyc(100);
    wb_xfer(1'b0, `STAT_ADDR, 32'h0, d);
    compare(d, 32'h1);
    compare(pins(), 32'h38);
    // Bus clock runs at 100 MHz, far above the floor for clock checking
    // clock check allowed
    wb_xfer(1'b1, `CTRL_ADDR, 32'h3, d);
    s = n_oe;
    enter_mode(1'b1);
    wait_cyc(520);
    compare(n_oe - s, 4);
    wait_run(d);
    wb_xfer(1'b0, `CTRL_ADDR, 32'h0, d);
    compare(d, 32'h4);
    wb_xfer(1'b0, `CTRL_ADDR, 32'h0, d);
    compare(d, 32'h0);
    wb_xfer(1'b1, `CTRL_ADDR, 32'h1, d);
    clock_absent_i <= 1'b1;
    wait_cyc(700);
    compare({31'h0, reset_n_pin_oe_o}, 32'h1);
    clock_absent_i <= 1'b0;
    wait_run(d);
    compare(d, 32'h1);
    wb_xfer(1'b1, `CTRL_ADDR, 32'h2, d);
    enter_mode(1'b1);
    s = n_spi;
    rst_req <= 1'b1;
    wait_cyc(40);
    wb_xfer(1'b0, `STAT_ADDR, 32'h0, d);
    compare(d, 32'h8);
    rst_req <= 1'b0;
    compare({31'h0, n_spi != s}, 32'h1);
    wait_run(d);
    wb_xfer(1'b0, `CTRL_ADDR, 32'h0, d);
    compare(d & 32'h2, 32'h0);
    s = n_sys;
    wait_cyc(200);
    compare(n_sys - s, 0);
    complete_run();
  end
endmodule

`default_nettype wire

// >>> test/lowpwr_ext_party.sv
// Model of the external reset and interrupt sources
`timescale 1ns/1ps
`default_nettype none

module lowpwr_ext_party #(
  parameter int SLOW = 0
) (
  input wire logic clk_i,
  input wire logic irq_req_i,
  input wire logic rst_req_i,
  input wire logic reset_n_pin_oe_i,
  output logic irq_n_pin_o,
  output logic reset_n_pin_o
);
  logic [3:0] irq_pipe = 4'h0;
  logic hold_reset = 1'b0;

  // A slow source lets the interrupt reach the pin a few cycles late
  always_ff @(posedge clk_i) begin
    irq_pipe <= {irq_pipe[2:0], irq_req_i};
  end
  assign irq_n_pin_o = !((SLOW != 0) ? irq_pipe[3] : irq_pipe[0]);

  always_ff @(posedge clk_i) begin
    hold_reset <= rst_req_i;
  end
  // Open drain with a pull-up: low while either party pulls
  assign reset_n_pin_o = !(hold_reset || reset_n_pin_oe_i);
endmodule

`default_nettype wire
